// ===== src/timer16_pkg.sv
package timer16_pkg;

  // Counter width and bus geometry.
  localparam int CNT_W  = 16;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_MODE_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_CAP_CTRL  = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_PRESCALE  = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_OUT_CTRL  = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_COUNT     = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_CC_A      = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_CC_B      = 5'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 5'h1c;

  // Field positions.
  localparam int MODE_HI     = 3;
  localparam int MODE_LO     = 2;
  localparam int TOG_SEL_BIT = 1;
  localparam int CAP_A_BIT   = 0;
  localparam int REV_BIT     = 1;
  localparam int CAP_B_BIT   = 2;
  localparam int CLK_SEL_HI  = 1;
  localparam int CLK_SEL_LO  = 0;
  localparam int EDGE_A_HI   = 4;
  localparam int EDGE_A_LO   = 3;
  localparam int EDGE_B_HI   = 6;
  localparam int EDGE_B_LO   = 5;
  localparam int OUT_EN_BIT  = 0;
  localparam int MASK_A_BIT  = 0;
  localparam int MASK_B_BIT  = 1;

  // Operating modes.
  localparam logic [1:0] MODE_STOP      = 2'h0;
  localparam logic [1:0] MODE_FREE      = 2'h1;
  localparam logic [1:0] MODE_EDGE_CLR  = 2'h2;
  localparam logic [1:0] MODE_MATCH_CLR = 2'h3;

  // Count clock selections and divider masks.
  localparam logic [1:0] CLK_DIV1   = 2'h0;
  localparam logic [1:0] CLK_DIV4   = 2'h1;
  localparam logic [1:0] CLK_DIV256 = 2'h2;
  localparam logic [1:0] CLK_TRIG_A = 2'h3;
  localparam logic [7:0] DIV4_LAST   = 8'h03;
  localparam logic [7:0] DIV256_LAST = 8'hff;
  localparam logic [7:0] DIV4_MASK   = 8'h03;

  // Edge selections.
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

endpackage : timer16_pkg

// ===== src/trigger_edge_filter.sv
`timescale 1ns/1ps
module trigger_edge_filter
  import timer16_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       ce_in,
  input  wire logic       pin_in,
  input  wire logic [1:0] edge_sel_in,
  output logic            valid_edge_out,
  output logic            reverse_edge_out
);

  logic sync1_reg, sync2_reg, samp_reg, level_reg, valid_reg, rev_reg;
  logic samp_next, level_next, valid_next, rev_next;
  logic rise, fall;

  // Accept a new level only after two equal samples, then pick edges.
  always_comb
  begin
    samp_next  = sync2_reg;
    level_next = (sync2_reg == samp_reg) ? samp_reg : level_reg; // [R18]
    rise       = level_next & ~level_reg;
    fall       = ~level_next & level_reg;
    case (edge_sel_in)
      EDGE_FALL:
      begin
        valid_next = fall;
        rev_next   = rise;
      end
      EDGE_RISE:
      begin
        valid_next = rise;
        rev_next   = fall;
      end
      EDGE_BOTH:
      begin
        valid_next = rise | fall;
        rev_next   = 1'b0;
      end
      default:
      begin
        valid_next = 1'b0;
        rev_next   = 1'b0;
      end
    endcase
  end

  // Synchroniser, filter and edge flops.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      samp_reg  <= 1'b0;
      level_reg <= 1'b0;
      valid_reg <= 1'b0;
      rev_reg   <= 1'b0;
    end
    else if (ce_in)
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      samp_reg  <= samp_next;
      level_reg <= level_next;
      valid_reg <= valid_next;
      rev_reg   <= rev_next;
    end
  end

  assign valid_edge_out   = valid_reg;
  assign reverse_edge_out = rev_reg;

endmodule : trigger_edge_filter

// ===== src/count_tick_gen.sv
`timescale 1ns/1ps
module count_tick_gen
  import timer16_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       ce_in,
  input  wire logic [1:0] clk_sel_in,
  input  wire logic       trig_a_edge_in,
  output logic            tick_out
);

  logic [7:0] div_reg, div_next;
  logic       tick_reg, tick_next;

  // Free-running divider; the selection picks which wrap gives a tick.
  always_comb
  begin
    div_next = div_reg + 8'h01;
    case (clk_sel_in)
      CLK_DIV1:   tick_next = 1'b1;
      CLK_DIV4:   tick_next = (div_reg & DIV4_MASK) == DIV4_LAST;
      CLK_DIV256: tick_next = div_reg == DIV256_LAST;
      CLK_TRIG_A: tick_next = trig_a_edge_in;
      default:    tick_next = 1'b0;
    endcase
  end

  // Divider and tick flops.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      div_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;

endmodule : count_tick_gen

// ===== src/edge_clear_capture_timer16.sv
// What this block does
// R1: Event counting: interrupt A after compare A value plus one events.
// R2: Software never loads compare A with zero in event or clear use.
// R3: Match on B raises interrupt B even unused; software masks it.
// R4: Mode field value 10 counts up on each count clock, clear-on-edge.
// R5: A valid trigger A edge clears the counter, then counting resumes.
// R6: Without trigger A edges the counter wraps past maximum and continues.
// R7: Counting starts at once on entering the mode, no first edge wait.
// R8: Compare A or B equal to counter raises interrupt A or B.
// R9: Capture A copies counter on trigger B edge and raises interrupt A.
// R10: Capture B copies counter on trigger A edge, interrupt B, then clears.
// R11: Software must not pick trigger A edges as count clock here.
// R12: Output toggles on matches; with toggle select also on trigger A edges.
// R13: Reverse-phase select captures A on opposite edge without interrupt A.
// R14: With reverse phase, trigger B edge raises interrupt A, no capture.
// R15: Software ignores the toggle output while trigger B detection is used.
// R16: Software reads both captures after interrupt B to get pulse widths.
// R17: Reading the counter returns the live count without disturbing it.
// R18: Trigger A edge accepted only after two consecutive equal samples.
// R19: Clear and match in one tick: clear, flag match, toggle per source.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module edge_clear_capture_timer16
  import timer16_pkg::*;
#(
  parameter int WIDTH = CNT_W
)
(
  input  wire logic              CLK_IN,
  input  wire logic              RESETN_IN,
  input  wire logic              CE_IN,
  input  wire logic [ADDR_W-1:0] ADDRESS_IN,
  input  wire logic              READ_IN,
  input  wire logic              WRITE_IN,
  input  wire logic [DATA_W-1:0] WRITEDATA_IN,
  input  wire logic [3:0]        BYTEENABLE_IN,
  output logic      [DATA_W-1:0] READDATA_OUT,
  output logic                   WAITREQUEST_OUT,
  input  wire logic              TRIGGER_INPUT_A_IN,
  input  wire logic              TRIGGER_INPUT_B_IN,
  output logic                   TIMER_TOGGLE_OUT,
  output logic                   MATCH_A_INTERRUPT_OUT,
  output logic                   MATCH_B_INTERRUPT_OUT
);

  // Refuse widths that the bus lanes or the counter cannot serve.
  if (WIDTH < 2 || WIDTH > CNT_W)
  begin : g_width_check
    $error("edge_clear_capture_timer16: WIDTH out of range");
  end

  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_e;

  bus_state_e        bus_state_reg, bus_state_next;
  logic              wait_reg, wait_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [7:0]        mode_ctrl_reg, mode_ctrl_next;
  logic [7:0]        cap_ctrl_reg, cap_ctrl_next;
  logic [7:0]        prescale_reg, prescale_next;
  logic [7:0]        out_ctrl_reg, out_ctrl_next;
  logic [1:0]        mask_reg, mask_next;
  logic [WIDTH-1:0]  cnt_reg, cnt_next;
  logic [WIDTH-1:0]  cc_a_reg, cc_a_next;
  logic [WIDTH-1:0]  cc_b_reg, cc_b_next;
  logic              tog_reg, tog_next;
  logic              irq_a_reg, irq_a_next;
  logic              irq_b_reg, irq_b_next;

  logic [1:0] mode;
  logic       running, tick, trig_a_edge, trig_a_rev, trig_b_edge;
  logic       cap_a_mode, cap_b_mode, rev_sel, out_en, tog_sel;
  logic       match_a_hit, match_b_hit, cap_a_evt, cap_b_evt;
  logic       edge_clear, bus_wr;

  // Trigger A: synchronised, noise-filtered, edge selected.
  trigger_edge_filter u_trig_a (
    .clk_in           (CLK_IN),
    .resetn_in        (RESETN_IN),
    .ce_in            (CE_IN),
    .pin_in           (TRIGGER_INPUT_A_IN),
    .edge_sel_in      (prescale_reg[EDGE_A_HI:EDGE_A_LO]),
    .valid_edge_out   (trig_a_edge),
    .reverse_edge_out (trig_a_rev)
  );

  // Trigger B: only its valid edge is used.
  trigger_edge_filter u_trig_b (
    .clk_in           (CLK_IN),
    .resetn_in        (RESETN_IN),
    .ce_in            (CE_IN),
    .pin_in           (TRIGGER_INPUT_B_IN),
    .edge_sel_in      (prescale_reg[EDGE_B_HI:EDGE_B_LO]),
    .valid_edge_out   (trig_b_edge),
    .reverse_edge_out ()
  );

  // Count clock from the prescaler or from trigger A edges.
  count_tick_gen u_tick (
    .clk_in         (CLK_IN),
    .resetn_in      (RESETN_IN),
    .ce_in          (CE_IN),
    .clk_sel_in     (prescale_reg[CLK_SEL_HI:CLK_SEL_LO]),
    .trig_a_edge_in (trig_a_edge),
    .tick_out       (tick)
  );

  // Merge a bus write into a counter-wide register by byte lane.
  function automatic logic [WIDTH-1:0] merge_lanes(
    input logic [WIDTH-1:0]  old_val,
    input logic [DATA_W-1:0] wdata,
    input logic [3:0]        be
  );
    logic [WIDTH-1:0] res;
    res = old_val;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (be[i/8])
      begin
        res[i] = wdata[i];
      end
    end
    return res;
  endfunction : merge_lanes

  // Decoded control fields.
  always_comb
  begin
    mode       = mode_ctrl_reg[MODE_HI:MODE_LO];
    tog_sel    = mode_ctrl_reg[TOG_SEL_BIT];
    cap_a_mode = cap_ctrl_reg[CAP_A_BIT];
    rev_sel    = cap_ctrl_reg[REV_BIT];
    cap_b_mode = cap_ctrl_reg[CAP_B_BIT];
    out_en     = out_ctrl_reg[OUT_EN_BIT];
    running    = mode != MODE_STOP;
  end

  // Events of this cycle: matches on a count tick, captures and the edge clear.
  always_comb
  begin
    match_a_hit = running & tick & ~cap_a_mode
                  & (cnt_reg == cc_a_reg);                   // [R8] [R1]
    match_b_hit = running & tick & ~cap_b_mode
                  & (cnt_reg == cc_b_reg);                   // [R8] [R3]
    cap_a_evt   = running & cap_a_mode
                  & (rev_sel ? trig_a_rev : trig_b_edge);    // [R9] [R13]
    cap_b_evt   = running & cap_b_mode & trig_a_edge;        // [R10]
    edge_clear  = (mode == MODE_EDGE_CLR) & trig_a_edge;     // [R5]
  end

  // Counter: counts from entry, clears on edge or match, wraps otherwise.
  always_comb
  begin
    cnt_next = cnt_reg;
    if (!running)
    begin
      cnt_next = '0;
    end
    else if (edge_clear)
    begin
      cnt_next = '0;                                         // [R5] [R10] [R19]
    end
    else if (tick)
    begin
      if (mode == MODE_MATCH_CLR && match_a_hit)
      begin
        cnt_next = '0;                                       // [R1]
      end
      else
      begin
        cnt_next = cnt_reg + WIDTH'(1);                      // [R4] [R6] [R7]
      end
    end
  end

  // Interrupt pulses, gated by the mask, and the toggle output.
  always_comb
  begin
    irq_a_next = (match_a_hit | (running & cap_a_mode & trig_b_edge))
                 & ~mask_reg[MASK_A_BIT];                    // [R9] [R14]
    irq_b_next = (match_b_hit | cap_b_evt)
                 & ~mask_reg[MASK_B_BIT];                    // [R3] [R10]
    tog_next   = 1'b0;
    if (out_en)
    begin
      tog_next = tog_reg ^ match_a_hit ^ match_b_hit
                 ^ (tog_sel & running & trig_a_edge);        // [R12] [R19]
    end
  end

  // Bus handshake: take a request while idle, answer one cycle later.
  always_comb
  begin
    bus_state_next = bus_state_reg;
    rdata_next     = rdata_reg;
    bus_wr         = 1'b0;
    case (bus_state_reg)
      BUS_IDLE:
      begin
        if (READ_IN || WRITE_IN)
        begin
          bus_state_next = BUS_ANSWER;
          rdata_next     = '0;
          if (READ_IN)
          begin
            case (ADDRESS_IN)
              OFF_MODE_CTRL: rdata_next[7:0] = mode_ctrl_reg;
              OFF_CAP_CTRL:  rdata_next[7:0] = cap_ctrl_reg;
              OFF_PRESCALE:  rdata_next[7:0] = prescale_reg;
              OFF_OUT_CTRL:  rdata_next[7:0] = out_ctrl_reg;
              OFF_COUNT:     rdata_next[WIDTH-1:0] = cnt_reg;  // [R17]
              OFF_CC_A:      rdata_next[WIDTH-1:0] = cc_a_reg;
              OFF_CC_B:      rdata_next[WIDTH-1:0] = cc_b_reg;
              OFF_IRQ_MASK:  rdata_next[1:0] = mask_reg;
              default:       rdata_next = '0;
            endcase
          end
        end
      end
      BUS_ANSWER:
      begin
        bus_state_next = BUS_IDLE;
        bus_wr         = WRITE_IN;
      end
      default:
      begin
        bus_state_next = BUS_IDLE;
      end
    endcase
    wait_next = bus_state_next != BUS_ANSWER;
  end

  // Register writes; a capture in the same cycle wins over software.
  always_comb
  begin
    mode_ctrl_next = mode_ctrl_reg;
    cap_ctrl_next  = cap_ctrl_reg;
    prescale_next  = prescale_reg;
    out_ctrl_next  = out_ctrl_reg;
    mask_next      = mask_reg;
    cc_a_next      = cc_a_reg;
    cc_b_next      = cc_b_reg;
    if (bus_wr && BYTEENABLE_IN[0])
    begin
      case (ADDRESS_IN)
        OFF_MODE_CTRL: mode_ctrl_next = WRITEDATA_IN[7:0];
        OFF_CAP_CTRL:  cap_ctrl_next  = WRITEDATA_IN[7:0];
        OFF_PRESCALE:  prescale_next  = WRITEDATA_IN[7:0];
        OFF_OUT_CTRL:  out_ctrl_next  = WRITEDATA_IN[7:0];
        OFF_IRQ_MASK:  mask_next      = WRITEDATA_IN[1:0];
        default:       mask_next      = mask_reg;
      endcase
    end
    if (bus_wr && ADDRESS_IN == OFF_CC_A)
    begin
      cc_a_next = merge_lanes(cc_a_reg, WRITEDATA_IN, BYTEENABLE_IN);
    end
    if (bus_wr && ADDRESS_IN == OFF_CC_B)
    begin
      cc_b_next = merge_lanes(cc_b_reg, WRITEDATA_IN, BYTEENABLE_IN);
    end
    if (cap_a_evt)
    begin
      cc_a_next = cnt_reg;                                   // [R9] [R13]
    end
    if (cap_b_evt)
    begin
      cc_b_next = cnt_reg;                                   // [R10]
    end
  end

  // All block state; a low clock enable freezes everything.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      bus_state_reg <= BUS_IDLE;
      wait_reg      <= 1'b1;
      rdata_reg     <= '0;
      mode_ctrl_reg <= '0;
      cap_ctrl_reg  <= '0;
      prescale_reg  <= '0;
      out_ctrl_reg  <= '0;
      mask_reg      <= '0;
      cnt_reg       <= '0;
      cc_a_reg      <= '0;
      cc_b_reg      <= '0;
      tog_reg       <= 1'b0;
      irq_a_reg     <= 1'b0;
      irq_b_reg     <= 1'b0;
    end
    else if (CE_IN)
    begin
      bus_state_reg <= bus_state_next;
      wait_reg      <= wait_next;
      rdata_reg     <= rdata_next;
      mode_ctrl_reg <= mode_ctrl_next;
      cap_ctrl_reg  <= cap_ctrl_next;
      prescale_reg  <= prescale_next;
      out_ctrl_reg  <= out_ctrl_next;
      mask_reg      <= mask_next;
      cnt_reg       <= cnt_next;
      cc_a_reg      <= cc_a_next;
      cc_b_reg      <= cc_b_next;
      tog_reg       <= tog_next;
      irq_a_reg     <= irq_a_next;
      irq_b_reg     <= irq_b_next;
    end
  end

  // Outputs straight from flops.
  assign READDATA_OUT          = rdata_reg;
  assign WAITREQUEST_OUT       = wait_reg;
  assign TIMER_TOGGLE_OUT      = tog_reg;
  assign MATCH_A_INTERRUPT_OUT = irq_a_reg;
  assign MATCH_B_INTERRUPT_OUT = irq_b_reg;

  // Checks on the counter, captures, interrupts and toggle output.
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  edge_clears_cnt_a: assert property ( // [R5]
    CE_IN && mode == MODE_EDGE_CLR && trig_a_edge |=> cnt_reg == '0)
    else $error("trigger A edge did not clear the counter");

  tick_counts_up_a: assert property ( // [R4]
    CE_IN && mode == MODE_EDGE_CLR && tick && !trig_a_edge
    |=> cnt_reg == WIDTH'($past(cnt_reg) + WIDTH'(1)))
    else $error("counter did not step on a count tick");

  match_clear_a: assert property ( // [R1]
    CE_IN && mode == MODE_MATCH_CLR && tick && !cap_a_mode
    && cnt_reg == cc_a_reg |=> cnt_reg == '0)
    else $error("match on A did not restart the count");

  match_irq_a: assert property ( // [R8]
    CE_IN && match_a_hit && !mask_reg[MASK_A_BIT]
    |=> MATCH_A_INTERRUPT_OUT)
    else $error("compare match A gave no interrupt A");

  capture_b_clear_a: assert property ( // [R10]
    CE_IN && cap_b_evt && mode == MODE_EDGE_CLR
    |=> cc_b_reg == $past(cnt_reg) && cnt_reg == '0)
    else $error("capture B did not store and clear");

  reverse_no_irq_a: assert property ( // [R13]
    CE_IN && running && cap_a_mode && rev_sel && trig_a_rev
    && !trig_b_edge |=> !MATCH_A_INTERRUPT_OUT && cc_a_reg == $past(cnt_reg))
    else $error("reverse phase capture misbehaved");

  reverse_b_irq_a: assert property ( // [R14]
    CE_IN && running && cap_a_mode && rev_sel && trig_b_edge && !trig_a_rev
    && !mask_reg[MASK_A_BIT] && !bus_wr
    |=> MATCH_A_INTERRUPT_OUT && $stable(cc_a_reg))
    else $error("trigger B in reverse phase mishandled");

  toggle_hold_a: assert property ( // [R12]
    CE_IN && out_en && !match_a_hit && !match_b_hit
    && !(tog_sel && running && trig_a_edge) |=> $stable(TIMER_TOGGLE_OUT))
    else $error("toggle output changed without a cause");

  mask_b_irq_a: assert property ( // [R3]
    CE_IN && running && tick && !cap_b_mode && cnt_reg == cc_b_reg
    && !mask_reg[MASK_B_BIT] |=> MATCH_B_INTERRUPT_OUT)
    else $error("unmasked match on B gave no interrupt B");

endmodule : edge_clear_capture_timer16

// ===== verif/trigger_pin_model.sv
`timescale 1ns/1ps
// Stands in for the two sources wired to the trigger pins.
module trigger_pin_model
(
  input  wire logic clk_in,
  output logic      trig_a_out,
  output logic      trig_b_out
);
  // Both pins rest low until a scenario moves them.
  initial
  begin
    trig_a_out = 1'b0;
    trig_b_out = 1'b0;
  end

  // Moves pin A after an edge and holds it long enough to pass the filter.
  task automatic drive_a(input logic lvl, input int hold);
    @(posedge clk_in);
    trig_a_out <= lvl;
    repeat (hold) @(posedge clk_in);
  endtask : drive_a

  // Moves pin B the same way as pin A.
  task automatic drive_b(input logic lvl, input int hold);
    @(posedge clk_in);
    trig_b_out <= lvl;
    repeat (hold) @(posedge clk_in);
  endtask : drive_b

  // A one-cycle dip on pin A that the filter has to swallow.
  task automatic glitch_a();
    @(posedge clk_in);
    trig_a_out <= ~trig_a_out;
    @(posedge clk_in);
    trig_a_out <= ~trig_a_out;
  endtask : glitch_a
endmodule : trigger_pin_model

// ===== verif/edge_clear_capture_timer16_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) \
    begin \
      err_total++; \
      $display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module edge_clear_capture_timer16_test
  import timer16_pkg::*;
;
  logic              clk;
  logic              resetn;
  logic [ADDR_W-1:0] addr;
  logic              rd_en;
  logic              wr_en;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              wait_q;
  logic              trig_a;
  logic              trig_b;
  logic              tog;
  logic              tog_q;
  logic              irq_a;
  logic              irq_b;
  logic [DATA_W-1:0] q;
  logic [7:0]        c0;
  int                err_total;
  int                checks_done;
  int                cyc;
  int                ia;
  int                ib;
  int                tg;
  int                ta;
  int                tb;
  int                ia0;
  int                ib0;
  int                tg0;

  // The counter is cut to eight bits so a wrap comes quickly.
  edge_clear_capture_timer16 #(.WIDTH(8)) u_edge_clear_capture_timer16 (
    .CLK_IN                (clk),
    .RESETN_IN             (resetn),
    .CE_IN                 (1'b1),
    .ADDRESS_IN            (addr),
    .READ_IN               (rd_en),
    .WRITE_IN              (wr_en),
    .WRITEDATA_IN          (wdata),
    .BYTEENABLE_IN         (4'hf),
    .READDATA_OUT          (rdata),
    .WAITREQUEST_OUT       (wait_q),
    .TRIGGER_INPUT_A_IN    (trig_a),
    .TRIGGER_INPUT_B_IN    (trig_b),
    .TIMER_TOGGLE_OUT      (tog),
    .MATCH_A_INTERRUPT_OUT (irq_a),
    .MATCH_B_INTERRUPT_OUT (irq_b)
  );

  // The pin sources sit on the far side of the trigger inputs.
  trigger_pin_model u_trigger_pin_model (
    .clk_in     (clk),
    .trig_a_out (trig_a),
    .trig_b_out (trig_b)
  );

  // The clock runs at 25 MHz.
  always #20 clk = ~clk;

  // Counts interrupt pulses and output flips, stamping the cycle of each interrupt pulse.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    tog_q <= tog;
    if (irq_a === 1'b1)
    begin
      ia <= ia + 1;
      ta <= cyc;
    end
    if (irq_b === 1'b1)
    begin
      ib <= ib + 1;
      tb <= cyc;
    end
    if (tog !== tog_q)
      tg <= tg + 1;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // One bus transfer, held until waitrequest is sampled low; data lands in q.
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= wr;
    rd_en <= ~wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_q !== 1'b0 && n < 20);
    q = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (wait_q !== 1'b0)
    begin
      err_total++;
      report_and_stop();
    end
  endtask : bus

  // Takes a snapshot of the event counters.
  task automatic snap();
    ia0 = ia;
    ib0 = ib;
    tg0 = tg;
  endtask : snap

  // Clears the counter with a rising pin A edge, then idles n cycles.
  task automatic clr_run(input int n);
    u_trigger_pin_model.drive_a(1'b0, 8);
    u_trigger_pin_model.drive_a(1'b1, 8);
    snap();
    repeat (n) @(posedge clk);
  endtask : clr_run

  // Main sequence: reset, then one scenario after another.
  initial
  begin
    logic [ADDR_W-1:0] offs [9];
    offs = '{OFF_MODE_CTRL, OFF_CAP_CTRL, OFF_PRESCALE, OFF_OUT_CTRL,
             OFF_COUNT, OFF_CC_A, OFF_CC_B, OFF_IRQ_MASK, 5'h02};
    clk = 1'b0;
    resetn = 1'b0;
    addr = '0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdata = '0;
    tog_q = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    // Every register and an unmapped place read zero after reset.
    bus(1'b1, 5'h02, 32'hffff_ffff);
    foreach (offs[i])
    begin
      bus(1'b0, offs[i], '0);
      `CHK("reset value", 32'h0, q);
    end
    // Edge-clear mode counts from entry and keeps running through reads.
    bus(1'b1, OFF_PRESCALE, 32'h0000_0048);
    bus(1'b1, OFF_MODE_CTRL, 32'h0000_0008);
    bus(1'b0, OFF_COUNT, '0);
    c0 = q[7:0];
    `CHK("count started", 8'h01, c0);
    bus(1'b0, OFF_COUNT, '0);
    `CHK("count step", 8'(c0 + 8'h03), q[7:0]);
    c0 = q[7:0];
    repeat (300) @(posedge clk);
    bus(1'b0, OFF_COUNT, '0);
    `CHK("count wrap", 8'(c0 + 8'h2f), q[7:0]);
    // Slower count clocks step once in every 4 and every 256 cycles.
    bus(1'b1, OFF_PRESCALE, 32'h0000_0049);
    bus(1'b0, OFF_COUNT, '0);
    c0 = q[7:0];
    repeat (1) @(posedge clk);
    bus(1'b0, OFF_COUNT, '0);
    `CHK("div4 step", 8'(c0 + 8'h01), q[7:0]);
    bus(1'b1, OFF_PRESCALE, 32'h0000_004a);
    bus(1'b0, OFF_COUNT, '0);
    c0 = q[7:0];
    repeat (253) @(posedge clk);
    bus(1'b0, OFF_COUNT, '0);
    `CHK("div256 step", 8'(c0 + 8'h01), q[7:0]);
    bus(1'b1, OFF_PRESCALE, 32'h0000_0048);
    // Capture B on pin A edges, with and without toggle on the edge.
    bus(1'b1, OFF_CAP_CTRL, 32'h0000_0004);
    bus(1'b1, OFF_OUT_CTRL, 32'h0000_0001);
    bus(1'b1, OFF_CC_A, 32'h0000_00f0);
    bus(1'b1, OFF_MODE_CTRL, 32'h0000_000a);
    clr_run(0);
    u_trigger_pin_model.drive_a(1'b0, 8);
    u_trigger_pin_model.drive_a(1'b1, 12);
    bus(1'b0, OFF_COUNT, '0);
    `CHK("count cleared", 1'b1, q[7:0] < 8'h20);
    `CHK("capture irq", 1, ib - ib0);
    `CHK("edge toggle", 1, tg - tg0);
    bus(1'b0, OFF_CC_B, '0);
    `CHK("capture b", 1'b1, q[7:0] inside {[8'h08:8'h20]});
    bus(1'b1, OFF_MODE_CTRL, 32'h0000_0008);
    snap();
    u_trigger_pin_model.drive_a(1'b0, 8);
    u_trigger_pin_model.drive_a(1'b1, 8);
    `CHK("no edge toggle", 0, tg - tg0);
    // A one-cycle dip must not count as an edge.
    snap();
    u_trigger_pin_model.glitch_a();
    repeat (12) @(posedge clk);
    `CHK("glitch", 0, ib - ib0);
    // Two compares after a clear, then with match B masked.
    bus(1'b1, OFF_CAP_CTRL, 32'h0000_0000);
    bus(1'b1, OFF_CC_A, 32'h0000_0060);
    bus(1'b1, OFF_CC_B, 32'h0000_0080);
    clr_run(150);
    `CHK("match a", 1, ia - ia0);
    `CHK("match b", 1, ib - ib0);
    `CHK("match gap", 32, tb - ta);
    `CHK("match toggles", 2, tg - tg0);
    bus(1'b1, OFF_IRQ_MASK, 32'h0000_0002);
    clr_run(150);
    `CHK("masked b", 0, ib - ib0);
    `CHK("unmasked a", 1, ia - ia0);
    bus(1'b1, OFF_IRQ_MASK, 32'h0000_0000);
    // Capture A on a rising pin B edge; toggle output is ignored here.
    bus(1'b1, OFF_CAP_CTRL, 32'h0000_0001);
    bus(1'b1, OFF_PRESCALE, 32'h0000_0028);
    clr_run(0);
    u_trigger_pin_model.drive_b(1'b1, 12);
    `CHK("capture a irq", 1, ia - ia0);
    bus(1'b0, OFF_CC_A, '0);
    `CHK("capture a", 1'b1, q[7:0] inside {[8'h01:8'h30]});
    // Pulse width: clear on fall, A on the reverse phase, B on fall.
    bus(1'b1, OFF_CAP_CTRL, 32'h0000_0007);
    bus(1'b1, OFF_PRESCALE, 32'h0000_0020);
    u_trigger_pin_model.drive_a(1'b0, 20);
    snap();
    u_trigger_pin_model.drive_a(1'b1, 30);
    u_trigger_pin_model.drive_a(1'b0, 12);
    `CHK("reverse no irq", 0, ia - ia0);
    `CHK("fall capture irq", 1, ib - ib0);
    bus(1'b0, OFF_CC_A, '0);
    c0 = q[7:0];
    // The clearing cycle holds zero, so A reads one below the low cycles.
    `CHK("low width", 8'h14, c0);
    bus(1'b0, OFF_CC_B, '0);
    `CHK("high width", 8'h1f, 8'(q[7:0] - c0));
    u_trigger_pin_model.drive_b(1'b0, 8);
    snap();
    u_trigger_pin_model.drive_b(1'b1, 12);
    `CHK("pin b irq", 1, ia - ia0);
    bus(1'b0, OFF_CC_A, '0);
    `CHK("pin b no capture", c0, q[7:0]);
    // Event counting: pin A edges are the count clock, compare value 3.
    bus(1'b1, OFF_MODE_CTRL, 32'h0000_0000);
    bus(1'b1, OFF_CAP_CTRL, 32'h0000_0000);
    bus(1'b1, OFF_PRESCALE, 32'h0000_001b);
    bus(1'b1, OFF_CC_A, 32'h0000_0003);
    bus(1'b1, OFF_MODE_CTRL, 32'h0000_000c);
    snap();
    repeat (3) u_trigger_pin_model.drive_a(~trig_a, 8);
    `CHK("three events", 0, ia - ia0);
    u_trigger_pin_model.drive_a(~trig_a, 8);
    `CHK("four events", 1, ia - ia0);
    report_and_stop();
  end
endmodule : edge_clear_capture_timer16_test
